// ---- verilog/dolm_matrix.sv ----
// Notes on behaviour
// [RL1] Each flag has its own mask choosing any subset of eight conditions.
// [RL2] Per-flag inversion mask negates conditions before selection for that flag.
// [RL3] Default flag combine is OR of selected conditions.
// [RL4] Flag AND-mode bit set: flag needs every selected condition.
// [RL5] Per-output mask inverts individual flags before second-stage selection.
// [RL6] Each output has a mask choosing any subset of eight flags.
// [RL7] Default output combine is OR of selected flags.
// [RL8] Output AND-mode bit set: output needs all selected flags.
// [RL9] Output inversion register inverts each output after combination.
// [RL10] Readable status of eight outputs before terminal allocation.
// [RL11] Post-allocation status: transistors bits 0-1, relays 2-3, internals 4-7.
// [RL12] Allocation: four 2-bit fields pick which of four signals drives each terminal.
// [RL13] Default allocation is one-to-one, value E4 hex.
// [RL14] All stages update together once per evaluation cycle from one snapshot.
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "dolm_defines.svh"
module dolm_matrix
  import dolm_pkg::*;
#(
  parameter int N = `DOLM_NUM
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [N-1:0] switching_condition_sources,
  output dolm_term_t terminals,
  output logic eval_tick
);
  dolm_bus_t bus;
  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  logic [7:0] cond_inv_ff [N];
  logic [7:0] cond_sel_ff [N];
  logic [7:0] out_finv_ff [N];
  logic [7:0] out_fsel_ff [N];
  logic [7:0] flag_and_ff, out_and_ff, out_inv_ff, alloc_ff, div_ff;
  logic [7:0] div_cnt_ff;
  logic [N-1:0] snap_ff, before_ff;
  dolm_term_t term_ff;
  logic [7:0] rdata_ff;

  wire [2:0] bank_idx = bus.addr[2:0];
  wire [4:0] bank_base = bus.addr & `DOLM_BANK_MASK;

  logic [2:0] ptr_ff;

  // One named write strobe per register or bank
  wire wr_cond_inv = bus.wr && (bank_base == `DOLM_A_COND_INV);
  wire wr_cond_sel = bus.wr && (bank_base == `DOLM_A_COND_SEL);
  wire wr_flag_and = bus.wr && (bus.addr == `DOLM_A_FLAG_AND);
  wire wr_out_finv = bus.wr && (bus.addr == `DOLM_A_OUT_FINV);
  wire wr_out_fsel = bus.wr && (bus.addr == `DOLM_A_OUT_FSEL);
  wire wr_out_and = bus.wr && (bus.addr == `DOLM_A_OUT_AND);
  wire wr_out_inv = bus.wr && (bus.addr == `DOLM_A_OUT_INV);
  wire wr_alloc = bus.wr && (bus.addr == `DOLM_A_ALLOC);
  wire wr_ptr = bus.wr && (bus.addr == `DOLM_A_ST_BEFORE);
  wire wr_ctrl = bus.wr && (bus.addr == `DOLM_A_CTRL);

  // First-stage banks, indexed by flag number
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < N; i++) begin
        cond_inv_ff[i] <= `DOLM_ZERO8;
        cond_sel_ff[i] <= `DOLM_ZERO8;
      end
    end else begin
      if (wr_cond_inv) cond_inv_ff[bank_idx] <= bus.wdata; // [RL2]
      if (wr_cond_sel) cond_sel_ff[bank_idx] <= bus.wdata; // [RL1]
    end
  end

  // Second-stage banks sit behind a pointer to keep the index map within 5 bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < N; i++) begin
        out_finv_ff[i] <= `DOLM_ZERO8;
        out_fsel_ff[i] <= `DOLM_ZERO8;
      end
    end else begin
      if (wr_out_finv) out_finv_ff[ptr_ff] <= bus.wdata; // [RL5]
      if (wr_out_fsel) out_fsel_ff[ptr_ff] <= bus.wdata; // [RL6]
    end
  end

  // Select write advances the pointer so all outputs load in one burst
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ptr_ff <= 3'h0;
    end else if (wr_ptr) begin
      ptr_ff <= bus.wdata[2:0];
    end else if (wr_out_fsel) begin
      ptr_ff <= ptr_ff + 3'h1;
    end
  end

  // Single-word controls of both stages
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_and_ff <= `DOLM_ZERO8;
      out_and_ff <= `DOLM_ZERO8;
      out_inv_ff <= `DOLM_ZERO8;
    end else begin
      if (wr_flag_and) flag_and_ff <= bus.wdata; // [RL4]
      if (wr_out_and) out_and_ff <= bus.wdata; // [RL8]
      if (wr_out_inv) out_inv_ff <= bus.wdata; // [RL9]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      alloc_ff <= `DOLM_ALLOC_RST; // [RL13]
      div_ff <= `DOLM_EVAL_DIV_DEF;
    end else begin
      if (wr_alloc) alloc_ff <= bus.wdata; // [RL12]
      if (wr_ctrl) div_ff <= bus.wdata;
    end
  end

  // Evaluation tick divider
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_cnt_ff <= `DOLM_ZERO8;
    end else if (eval_tick) begin
      div_cnt_ff <= `DOLM_ZERO8;
    end else begin
      div_cnt_ff <= div_cnt_ff + 8'h01;
    end
  end
  assign eval_tick = (div_cnt_ff + 8'h01) >= div_ff;

  // Stage one and stage two
  logic [N-1:0] flags;
  logic [N-1:0] outs_pre;
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_stage
      dolm_combine #(.N(N)) u_flag (
        .in_vec(snap_ff),
        .inv_mask(cond_inv_ff[g]), // [RL2]
        .sel_mask(cond_sel_ff[g]), // [RL1]
        .and_mode(flag_and_ff[g]), // [RL3] [RL4]
        .result(flags[g])
      );
      dolm_combine #(.N(N)) u_out (
        .in_vec(flags),
        .inv_mask(out_finv_ff[g]), // [RL5]
        .sel_mask(out_fsel_ff[g]), // [RL6]
        .and_mode(out_and_ff[g]), // [RL7] [RL8]
        .result(outs_pre[g])
      );
    end
  endgenerate

  wire [N-1:0] outs = outs_pre ^ out_inv_ff; // [RL9]

  // Allocation of the four physical signals onto terminals
  wire [3:0] phys = outs[3:0];
  wire [3:0] alloc_vec;
  generate
    for (g = 0; g < 4; g++) begin : g_alloc
      assign alloc_vec[g] = phys[alloc_ff[2*g +: 2]]; // [RL12]
    end
  endgenerate

  // Snapshot taken on tick, results latched on the next tick: one consistent image
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      snap_ff <= '0;
      before_ff <= '0;
      term_ff <= '0;
    end else if (eval_tick) begin
      snap_ff <= switching_condition_sources;
      before_ff <= outs; // [RL14] [RL10]
      term_ff <= {outs[7:4], alloc_vec}; // [RL14] [RL11]
    end
  end
  assign terminals = term_ff;

  // Read mux
  logic [7:0] rmux;
  always_comb begin
    rmux = `DOLM_ZERO8;
    if (bank_base == `DOLM_A_COND_INV) rmux = cond_inv_ff[bank_idx];
    else if (bank_base == `DOLM_A_COND_SEL) rmux = cond_sel_ff[bank_idx];
    else begin
      case (bus.addr)
        `DOLM_A_FLAG_AND: rmux = flag_and_ff;
        `DOLM_A_OUT_FINV: rmux = out_finv_ff[ptr_ff];
        `DOLM_A_OUT_FSEL: rmux = out_fsel_ff[ptr_ff];
        `DOLM_A_OUT_AND: rmux = out_and_ff;
        `DOLM_A_OUT_INV: rmux = out_inv_ff;
        `DOLM_A_ALLOC: rmux = alloc_ff;
        `DOLM_A_ST_AFTER: rmux = term_ff; // [RL11]
        `DOLM_A_ST_BEFORE: rmux = before_ff; // [RL10]
        `DOLM_A_CTRL: rmux = div_ff;
        default: rmux = `DOLM_ZERO8;
      endcase
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) rdata_ff <= `DOLM_ZERO8;
    else if (bus.rd) rdata_ff <= rmux;
    else rdata_ff <= `DOLM_ZERO8;
  end
  assign reg_rdata = rdata_ff;

  // Assertions
  status_match_a: assert property (@(posedge clk) disable iff (rst) // [RL11]
    $past(eval_tick) |-> terminals[7:4] == $past(outs[7:4]))
    else $error("internal outputs differ from pre-allocation status");
  alloc_route_a: assert property (@(posedge clk) disable iff (rst) // [RL12]
    $past(eval_tick) |-> terminals[0] == before_ff[$past(alloc_ff[1:0])])
    else $error("first transistor terminal misrouted");
  hold_between_a: assert property (@(posedge clk) disable iff (rst) // [RL14]
    !$past(eval_tick) |-> $stable(before_ff))
    else $error("status changed without evaluation tick");
  inv_apply_a: assert property (@(posedge clk) disable iff (rst) // [RL9]
    (!out_and_ff[0] && out_fsel_ff[0] == `DOLM_ZERO8) |-> outs[0] == out_inv_ff[0])
    else $error("output inversion not applied");
  rd_late_a: assert property (@(posedge clk) disable iff (rst) // [RL10]
    (bus.rd && bus.addr == `DOLM_A_ST_BEFORE) |=> reg_rdata == $past(before_ff))
    else $error("pre-allocation status read wrong");
  and_empty_a: assert property (@(posedge clk) disable iff (rst) // [RL8]
    (out_and_ff[0] && out_fsel_ff[0] == `DOLM_ZERO8) |-> outs_pre[0])
    else $error("empty AND selection must be true");
  or_empty_a: assert property (@(posedge clk) disable iff (rst) // [RL3]
    (!flag_and_ff[0] && cond_sel_ff[0] == `DOLM_ZERO8) |-> !flags[0])
    else $error("empty OR selection must be false");
  or_any_a: assert property (@(posedge clk) disable iff (rst) // [RL7]
    (!out_and_ff[1] && |(out_fsel_ff[1] & (flags ^ out_finv_ff[1]))) |-> outs_pre[1])
    else $error("OR output missed a selected flag");

  // Allocation and status
  route_term1_a: assert property (@(posedge clk) disable iff (rst) // [RL12]
    $past(eval_tick) |-> terminals[1] == before_ff[$past(alloc_ff[3:2])])
    else $error("second transistor terminal misrouted");
  route_term2_a: assert property (@(posedge clk) disable iff (rst) // [RL12]
    $past(eval_tick) |-> terminals[2] == before_ff[$past(alloc_ff[5:4])])
    else $error("first relay terminal misrouted");
  route_term3_a: assert property (@(posedge clk) disable iff (rst) // [RL12]
    $past(eval_tick) |-> terminals[3] == before_ff[$past(alloc_ff[7:6])])
    else $error("second relay terminal misrouted");
  before_take_a: assert property (@(posedge clk) disable iff (rst) // [RL10]
    eval_tick |=> before_ff == $past(outs))
    else $error("pre-allocation status not latched on tick");

  // Evaluation cycle
  snap_take_a: assert property (@(posedge clk) disable iff (rst) // [RL14]
    eval_tick |=> snap_ff == $past(switching_condition_sources))
    else $error("condition snapshot not taken on tick");
  term_hold_a: assert property (@(posedge clk) disable iff (rst) // [RL14]
    !$past(eval_tick) |-> $stable(term_ff))
    else $error("terminals changed without evaluation tick");
  tick_every_a: assert property (@(posedge clk) disable iff (rst) // [RL14]
    (div_ff <= 8'h01) |-> eval_tick)
    else $error("divider of one must tick every cycle");
  tick_gap_a: assert property (@(posedge clk) disable iff (rst) // [RL14]
    (eval_tick && !wr_ctrl && div_ff > 8'h01) |=> !eval_tick)
    else $error("ticks too close for divider");

  // First stage
  flag_or_any_a: assert property (@(posedge clk) disable iff (rst) // [RL3]
    (!flag_and_ff[1] && |(cond_sel_ff[1] & (snap_ff ^ cond_inv_ff[1]))) |-> flags[1])
    else $error("OR flag missed a selected condition");
  flag_and_miss_a: assert property (@(posedge clk) disable iff (rst) // [RL4]
    (flag_and_ff[2] && |(cond_sel_ff[2] & ~(snap_ff ^ cond_inv_ff[2]))) |-> !flags[2])
    else $error("AND flag set with a condition missing");
  flag_and_all_a: assert property (@(posedge clk) disable iff (rst) // [RL4]
    (flag_and_ff[3] && (cond_sel_ff[3] & ~(snap_ff ^ cond_inv_ff[3])) == `DOLM_ZERO8)
      |-> flags[3])
    else $error("AND flag clear with all conditions met");
  flag_inv_a: assert property (@(posedge clk) disable iff (rst) // [RL2]
    (!flag_and_ff[0] && cond_sel_ff[0] != `DOLM_ZERO8 && cond_inv_ff[0] == cond_sel_ff[0]
      && (snap_ff & cond_sel_ff[0]) == `DOLM_ZERO8) |-> flags[0])
    else $error("inverted condition not honoured");
  flag_sel_none_a: assert property (@(posedge clk) disable iff (rst) // [RL1]
    (!flag_and_ff[4] && (cond_sel_ff[4] & (snap_ff ^ cond_inv_ff[4])) == `DOLM_ZERO8)
      |-> !flags[4])
    else $error("unselected condition set a flag");

  // Second stage
  out_and_miss_a: assert property (@(posedge clk) disable iff (rst) // [RL8]
    (out_and_ff[2] && |(out_fsel_ff[2] & ~(flags ^ out_finv_ff[2]))) |-> !outs_pre[2])
    else $error("AND output set with a flag missing");
  out_and_all_a: assert property (@(posedge clk) disable iff (rst) // [RL8]
    (out_and_ff[4] && (out_fsel_ff[4] & ~(flags ^ out_finv_ff[4])) == `DOLM_ZERO8)
      |-> outs_pre[4])
    else $error("AND output clear with all flags set");
  out_or_none_a: assert property (@(posedge clk) disable iff (rst) // [RL7]
    (!out_and_ff[3] && (out_fsel_ff[3] & (flags ^ out_finv_ff[3])) == `DOLM_ZERO8)
      |-> !outs_pre[3])
    else $error("OR output set with no selected flag");
  out_finv_a: assert property (@(posedge clk) disable iff (rst) // [RL5]
    (!out_and_ff[5] && out_fsel_ff[5] != `DOLM_ZERO8 && out_finv_ff[5] == out_fsel_ff[5]
      && (flags & out_fsel_ff[5]) == `DOLM_ZERO8) |-> outs_pre[5])
    else $error("inverted flag not honoured");

  // Register port
  rd_after_a: assert property (@(posedge clk) disable iff (rst) // [RL11]
    (bus.rd && bus.addr == `DOLM_A_ST_AFTER) |=> reg_rdata == $past(term_ff))
    else $error("post-allocation status read wrong");
  rd_idle_a: assert property (@(posedge clk) disable iff (rst) // [RL10]
    !bus.rd |=> reg_rdata == `DOLM_ZERO8)
    else $error("read data present without read strobe");
  ptr_step_a: assert property (@(posedge clk) disable iff (rst) // [RL6]
    wr_out_fsel |=> ptr_ff == $past(ptr_ff) + 3'h1)
    else $error("output pointer did not advance");
endmodule // dolm_matrix
`default_nettype wire

// ---- verilog/dolm_defines.svh ----
`ifndef DOLM_DEFINES_SVH
`define DOLM_DEFINES_SVH

`define DOLM_NUM 8
`define DOLM_IDX_W 5
// Register indices on the plain port
`define DOLM_A_COND_INV 5'h00
`define DOLM_A_COND_SEL 5'h08
`define DOLM_A_FLAG_AND 5'h10
`define DOLM_A_OUT_FINV 5'h11
`define DOLM_A_OUT_FSEL 5'h12
`define DOLM_A_OUT_AND 5'h13
`define DOLM_A_OUT_INV 5'h14
`define DOLM_A_ALLOC 5'h15
`define DOLM_A_ST_AFTER 5'h16
`define DOLM_A_ST_BEFORE 5'h17
`define DOLM_A_CTRL 5'h18
`define DOLM_BANK_MASK 5'h18
`define DOLM_ALLOC_RST 8'hE4
`define DOLM_ZERO8 8'h00
`define DOLM_EVAL_DIV_DEF 8'h01

`endif

// ---- verilog/dolm_pkg.sv ----
`default_nettype none
package dolm_pkg;
  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } dolm_bus_t;

  typedef struct packed {
    logic internal_out_d;
    logic internal_out_c;
    logic internal_out_b;
    logic internal_out_a;
    logic relay_out_b;
    logic relay_out_a;
    logic transistor_out_b;
    logic transistor_out_a;
  } dolm_term_t;
endpackage
`default_nettype wire

// ---- verilog/dolm_combine.sv ----
`timescale 1ns/1ps
`default_nettype none
module dolm_combine #(
  parameter int N = 8
) (
  input wire logic [N-1:0] in_vec,
  input wire logic [N-1:0] inv_mask,
  input wire logic [N-1:0] sel_mask,
  input wire logic and_mode,
  output logic result
);
  wire [N-1:0] adj = in_vec ^ inv_mask;
  // Empty selection: OR gives 0, AND gives 1 (vacuous)
  wire or_res = |(adj & sel_mask);
  wire and_res = &(adj | ~sel_mask);
  assign result = and_mode ? and_res : or_res;
endmodule // dolm_combine
`default_nettype wire

// ---- bench/dolm_load.sv ----
`timescale 1ns/1ps
`default_nettype none
module dolm_load
  import dolm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire dolm_term_t terminals,
  output logic [7:0] load_on_ff
);
  // Loads pull in one cycle after their terminal, like a contactor coil
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      load_on_ff <= 8'h00;
    end else begin
      load_on_ff <= terminals;
    end
  end
endmodule // dolm_load
`default_nettype wire

// ---- bench/digital_output_logic_matrix_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dolm_defines.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module digital_output_logic_matrix_tb
  import dolm_pkg::*;
;
  logic clk, rst, wr, rd, tick;
  logic [4:0] addr;
  logic [7:0] wdata, rdata, src, load_on, s, b;
  dolm_term_t term;
  int bad_count, checks;
  logic [7:0] n;
  logic [7:0] cinv[8], csel[8], ofinv[8], ofsel[8];
  logic [7:0] fand, oand, oinv, alloc;

  dolm_matrix #(.N(8)) u_dut(.clk(clk), .rst(rst), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .switching_condition_sources(src),
    .terminals(term), .eval_tick(tick));
  dolm_load u_load(.clk(clk), .rst(rst), .terminals(term), .load_on_ff(load_on));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic chk_reg(input logic [4:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 `CHK(rdata, e)
  endtask

  function automatic logic [7:0] exp_before(input logic [7:0] x);
    logic [7:0] fl, v, r;
    for (int f = 0; f < 8; f++) begin
      v = (x ^ cinv[f]) & csel[f];
      fl[f] = fand[f] ? (v == csel[f]) : |v;
    end
    for (int o = 0; o < 8; o++) begin
      v = (fl ^ ofinv[o]) & ofsel[o];
      r[o] = (oand[o] ? (v == ofsel[o]) : |v) ^ oinv[o];
    end
    return r;
  endfunction

  function automatic logic [7:0] exp_after(input logic [7:0] x);
    exp_after = x;
    for (int t = 0; t < 4; t++) exp_after[t] = x[alloc[2*t +: 2]];
  endfunction

  // Deterministic spread of masks; k 0 is the plain one-to-one setup
  task automatic cfg(input int k);
    fand = 8'(k * 8'h5B);
    oand = 8'(k * 8'h33);
    oinv = 8'(k * 8'h6D);
    alloc = (k == 0) ? `DOLM_ALLOC_RST : 8'(k * 8'h4B + 8'h1E);
    for (int i = 0; i < 8; i++) begin
      cinv[i] = 8'(k * (i + 3) * 8'h17);
      csel[i] = (k == 0) ? 8'h01 << i : 8'((k + i) * 8'h29);
      ofinv[i] = 8'(k * (i + 1) * 8'h0D);
      ofsel[i] = (k == 0) ? 8'h01 << i : 8'((k * 3 + i) * 8'h45);
      wr_reg(`DOLM_A_COND_INV + 5'(i), cinv[i]);
      wr_reg(`DOLM_A_COND_SEL + 5'(i), csel[i]);
      wr_reg(`DOLM_A_ST_BEFORE, 8'(i));
      wr_reg(`DOLM_A_OUT_FINV, ofinv[i]);
      wr_reg(`DOLM_A_OUT_FSEL, ofsel[i]);
    end
    wr_reg(`DOLM_A_FLAG_AND, fand);
    wr_reg(`DOLM_A_OUT_AND, oand);
    wr_reg(`DOLM_A_OUT_INV, oinv);
    wr_reg(`DOLM_A_ALLOC, alloc);
  endtask

  task automatic end_of_test();
    $display("bad_count=%0d checks=%0d", bad_count, checks);
    if (bad_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #1ms;
    bad_count++;
    end_of_test();
  end

  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 5'h00;
    wdata = 8'h00;
    src = 8'h00;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    chk_reg(`DOLM_A_ALLOC, `DOLM_ALLOC_RST);
    chk_reg(`DOLM_A_FLAG_AND, 8'h00);
    chk_reg(5'h1F, 8'h00);
    `CHK(term, 8'h00)
    for (int k = 0; k < 4; k++) begin
      cfg(k);
      chk_reg(`DOLM_A_FLAG_AND, fand);
      chk_reg(`DOLM_A_OUT_AND, oand);
      chk_reg(`DOLM_A_ALLOC, alloc);
      for (int j = 0; j < 5; j++) begin
        s = (j == 0) ? 8'h00 : (j == 1) ? 8'hFF : 8'(j * 8'h5D + k * 8'h11);
        b = exp_before(s);
        @(posedge clk);
        src <= s;
        // Two ticks of latency, plus margin
        repeat (4) @(posedge clk);
        chk_reg(`DOLM_A_ST_BEFORE, b);
        chk_reg(`DOLM_A_ST_AFTER, exp_after(b));
        `CHK(term, exp_after(b))
        `CHK(load_on, exp_after(b))
      end
    end
    // Empty second-stage selection: OR gives 0, AND gives 1, then inverted
    for (int m = 0; m < 2; m++) begin
      ofinv[0] = 8'h00;
      ofsel[0] = 8'h00;
      oand = 8'(m);
      oinv = 8'h01;
      wr_reg(`DOLM_A_ST_BEFORE, 8'h00);
      wr_reg(`DOLM_A_OUT_FINV, ofinv[0]);
      wr_reg(`DOLM_A_OUT_FSEL, ofsel[0]);
      wr_reg(`DOLM_A_OUT_AND, oand);
      wr_reg(`DOLM_A_OUT_INV, oinv);
      repeat (4) @(posedge clk);
      chk_reg(`DOLM_A_ST_BEFORE, exp_before(src));
    end
    wr_reg(`DOLM_A_CTRL, 8'h03);
    repeat (3) @(posedge clk);
    n = 8'h00;
    repeat (30) begin
      @(posedge clk);
      #1 n = n + {7'h00, tick};
    end
    `CHK(n, 8'h0A)
    end_of_test();
  end
endmodule // digital_output_logic_matrix_tb
`default_nettype wire
